/* File: include/ind_regs_map.vh */
// register offsets, field positions, reset values and timing counts of the channel register bank
`ifndef IND_REGS_MAP_VH
`define IND_REGS_MAP_VH
`define CH2_RESULT_WITH_FLAGS_ADDR   8'h04
`define CH3_RESULT_WITH_FLAGS_ADDR   8'h06
`define CH0_CONVERSION_INTERVAL_ADDR 8'h08
`define CH1_CONVERSION_INTERVAL_ADDR 8'h09
`define CH2_CONVERSION_INTERVAL_ADDR 8'h0a
`define CH3_CONVERSION_INTERVAL_ADDR 8'h0b
`define CH0_FREQUENCY_OFFSET_ADDR    8'h0c
`define CH1_FREQUENCY_OFFSET_ADDR    8'h0d
`define UNDERRANGE_BIT               15
`define OVERRANGE_BIT                14
`define TIMEOUT_BIT                  13
`define AMPLITUDE_BIT                12
`define RESULT_MSB                   11
`define RESULT_RESET                 12'h000
`define INTERVAL_RESET               16'h0080
`define OFFSET_RESET                 16'h0000
`define UNMAPPED_READ                16'h0000
`define REF_PERIODS_PER_COUNT        5'h10
`endif

/* File: rtl/channel_result_config_regs.v */
// register bank: channel 2/3 results with read-clear flags, conversion intervals, channel 0/1 offsets
// Behaviour
// - bit 15 of each result register is the under-range flag, zero after reset
// - bit 14 of each result register is the over-range flag, zero after reset
// - bit 13 of each result register is the watchdog-timeout flag, zero after reset
// - bit 12 of each result register is the amplitude flag, zero after reset
// - reading a result register clears its flags; flags cannot be written
// - bits 11:0 hold the read-only 12-bit result, reset to zero
// - each channel has a 16-bit read-write interval register, reset 0x0080
// - conversion time equals interval times 16 reference clock periods
// - offset registers are 16-bit read-write, reset zero, driven to the core
// - amplitude flag sets on unsettled start when amplitude reporting is enabled
`timescale 1ns/1ns
module channel_result_config_regs (
  // clock and reset
  input  wire        clk_in,
  input  wire        arst_n_in,
  // register access port
  input  wire [7:0]  reg_addr_in,
  input  wire        reg_wr_en_in,
  input  wire [15:0] reg_wr_data_in,
  input  wire        reg_rd_en_in,
  output reg  [15:0] reg_rd_data_out,
  output reg         reg_rd_valid_out,
  // conversion core, channels 2 and 3 (index 0 = ch2)
  input  wire [1:0]  result_valid_in,
  input  wire [23:0] result_data_in,
  input  wire [1:0]  underrange_evt_in,
  input  wire [1:0]  overrange_evt_in,
  input  wire [1:0]  timeout_evt_in,
  input  wire [1:0]  amp_unsettled_evt_in,
  input  wire        amp_report_en_in,
  // conversion timing, all four channels
  input  wire [3:0]  run_in,
  input  wire [3:0]  ref_tick_in,
  output wire [3:0]  conv_done_out,
  output wire [3:0]  conv_busy_out,
  // settings to the core
  output wire [63:0] conversion_interval_out,
  output reg  [15:0] ch0_frequency_offset_out,
  output reg  [15:0] ch1_frequency_offset_out
);
`include "ind_regs_map.vh"
  wire [15:0] result_word [0:1];
  wire [1:0]  result_hit;

  assign result_hit[0] = (reg_addr_in == `CH2_RESULT_WITH_FLAGS_ADDR);
  assign result_hit[1] = (reg_addr_in == `CH3_RESULT_WITH_FLAGS_ADDR);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_result
      reg         underrange_r;
      reg         overrange_r;
      reg         timeout_r;
      reg         amplitude_r;
      reg  [11:0] result_r;
      wire        rd_clr;
      // a read only clears when its own address is read
      assign rd_clr = reg_rd_en_in & result_hit[ch];
      assign result_word[ch] = {underrange_r, overrange_r, timeout_r, amplitude_r, result_r};
      always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          underrange_r <= 1'b0;
          overrange_r  <= 1'b0;
          timeout_r    <= 1'b0;
          amplitude_r  <= 1'b0;
          result_r     <= `RESULT_RESET;
        end else begin
          // set wins over read clear so an event in the read cycle survives
          underrange_r <= (underrange_r & ~rd_clr) | underrange_evt_in[ch];
          overrange_r  <= (overrange_r & ~rd_clr) | overrange_evt_in[ch];
          timeout_r    <= (timeout_r & ~rd_clr) | timeout_evt_in[ch];
          amplitude_r  <= (amplitude_r & ~rd_clr) | (amp_unsettled_evt_in[ch] & amp_report_en_in);
          if (result_valid_in[ch]) begin
            result_r <= result_data_in[ch*12 +: 12];
          end
        end
      end
    end
  endgenerate

  // interval and offset registers
  wire [3:0] interval_hit;
  assign interval_hit[0] = (reg_addr_in == `CH0_CONVERSION_INTERVAL_ADDR);
  assign interval_hit[1] = (reg_addr_in == `CH1_CONVERSION_INTERVAL_ADDR);
  assign interval_hit[2] = (reg_addr_in == `CH2_CONVERSION_INTERVAL_ADDR);
  assign interval_hit[3] = (reg_addr_in == `CH3_CONVERSION_INTERVAL_ADDR);

  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_interval
      // one register per channel keeps a single driver for each slice
      reg [15:0] interval_r;
      assign conversion_interval_out[ch*16 +: 16] = interval_r;
      always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          interval_r <= `INTERVAL_RESET;
        end else if (reg_wr_en_in && interval_hit[ch]) begin
          // reserved values 0..4 are not trapped; the host keeps them out
          interval_r <= reg_wr_data_in;
        end
      end
      interval_timer u_timer (
        .clk_in        (clk_in),
        .arst_n_in     (arst_n_in),
        .run_in        (run_in[ch]),
        .ref_tick_in   (ref_tick_in[ch]),
        .interval_in   (conversion_interval_out[ch*16 +: 16]),
        .conv_done_out (conv_done_out[ch]),
        .busy_out      (conv_busy_out[ch])
      );
    end
  endgenerate

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ch0_frequency_offset_out <= `OFFSET_RESET;
      ch1_frequency_offset_out <= `OFFSET_RESET;
    end else if (reg_wr_en_in) begin
      if (reg_addr_in == `CH0_FREQUENCY_OFFSET_ADDR) begin
        ch0_frequency_offset_out <= reg_wr_data_in;
      end
      if (reg_addr_in == `CH1_FREQUENCY_OFFSET_ADDR) begin
        ch1_frequency_offset_out <= reg_wr_data_in;
      end
    end
  end

  // read mux; writes to result addresses are dropped, which also
  reg [15:0] rd_mux;
  always @* begin
    case (reg_addr_in)
      `CH2_RESULT_WITH_FLAGS_ADDR:   rd_mux = result_word[0];
      `CH3_RESULT_WITH_FLAGS_ADDR:   rd_mux = result_word[1];
      `CH0_CONVERSION_INTERVAL_ADDR: rd_mux = conversion_interval_out[15:0];
      `CH1_CONVERSION_INTERVAL_ADDR: rd_mux = conversion_interval_out[31:16];
      `CH2_CONVERSION_INTERVAL_ADDR: rd_mux = conversion_interval_out[47:32];
      `CH3_CONVERSION_INTERVAL_ADDR: rd_mux = conversion_interval_out[63:48];
      `CH0_FREQUENCY_OFFSET_ADDR:    rd_mux = ch0_frequency_offset_out;
      `CH1_FREQUENCY_OFFSET_ADDR:    rd_mux = ch1_frequency_offset_out;
      default:                       rd_mux = `UNMAPPED_READ;
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rd_data_out  <= 16'h0000;
      reg_rd_valid_out <= 1'b0;
    end else begin
      reg_rd_valid_out <= reg_rd_en_in;
      if (reg_rd_en_in) begin
        // whole word captured in the same edge that clears the flags
        reg_rd_data_out <= rd_mux;
      end
    end
  end
endmodule // channel_result_config_regs

/* File: rtl/interval_timer.v */
// conversion interval timer: one conversion lasts interval x 16 reference clock periods
`timescale 1ns/1ns
module interval_timer (
  // clock and reset
  input  wire        clk_in,
  input  wire        arst_n_in,
  // control
  input  wire        run_in,
  input  wire        ref_tick_in,
  input  wire [15:0] interval_in,
  // status
  output reg         conv_done_out,
  output reg         busy_out
);
`include "ind_regs_map.vh"
  reg [3:0]  sub_r;
  reg [15:0] count_r;
  reg [15:0] limit_r;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sub_r         <= 4'h0;
      count_r       <= 16'h0000;
      limit_r       <= `INTERVAL_RESET;
      conv_done_out <= 1'b0;
      busy_out      <= 1'b0;
    end else begin
      conv_done_out <= 1'b0;
      if (!run_in) begin
        busy_out <= 1'b0;
        sub_r    <= 4'h0;
        count_r  <= 16'h0000;
      end else if (!busy_out) begin
        // interval is latched at start so a write mid-conversion cannot tear it
        busy_out <= 1'b1;
        limit_r  <= interval_in;
        sub_r    <= 4'h0;
        count_r  <= 16'h0000;
      end else if (ref_tick_in) begin
        sub_r <= sub_r + 4'h1;
        if (sub_r == 4'hf) begin
          if (count_r + 16'h0001 >= limit_r) begin
            conv_done_out <= 1'b1;
            busy_out      <= 1'b0;
          end else begin
            count_r <= count_r + 16'h0001;
          end
        end
      end
    end
  end
endmodule // interval_timer

/* File: tb/channel_result_config_regs_tb_top.sv */
// testbench: reset values, settings, flags and conversion timing
`timescale 1ns/1ns
module channel_result_config_regs_tb_top;
  logic        clk_in = 0, arst_n_in = 0, reg_wr_en_in, reg_rd_en_in, reg_rd_valid_out, amp_report_en_in = 0;
  logic [7:0]  reg_addr_in, evt = 0;
  logic [15:0] reg_wr_data_in, reg_rd_data_out, ch0_frequency_offset_out, ch1_frequency_offset_out, v[6], q[$];
  logic [1:0]  result_valid_in = 0, underrange_evt_in, overrange_evt_in, timeout_evt_in, amp_unsettled_evt_in;
  logic [23:0] result_data_in = 0, d;
  logic [3:0]  run_in = 0, ref_tick_in = 0, conv_done_out, conv_busy_out;
  logic [63:0] conversion_interval_out;
  int          fails = 0, checks_done = 0, ticks, n;
  assign {underrange_evt_in, overrange_evt_in, timeout_evt_in, amp_unsettled_evt_in} = evt;
  always #10 clk_in = ~clk_in;
  ind_host_model host (.clk_in, .addr_out(reg_addr_in), .wr_out(reg_wr_en_in), .rd_out(reg_rd_en_in),
    .data_out(reg_wr_data_in));
  channel_result_config_regs uut (.*);
  task chk(input string s, input logic [63:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task stop_test;
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    q.push_back(e);
    host.acc(1'b0, a, 16'h0);
  endtask
  always @(posedge clk_in) begin
    if (reg_rd_valid_out === 1'b1) chk("read data", q.pop_front(), reg_rd_data_out);
    if (conv_busy_out[0] === 1'b1 && ref_tick_in[0] === 1'b1) ticks++;
  end
  initial begin
    void'($urandom(3250));
    repeat (6) @(posedge clk_in);
    #1 arst_n_in = 1;
    for (int i = 0; i < 9; i++)
      rd(i < 2 ? 8'(4 + 2 * i) : i < 8 ? 8'(6 + i) : 8'h20, i > 1 && i < 6 ? 16'h0080 : 16'h0);
    host.acc(1'b1, 8'h04, 16'hffff);
    rd(8'h04, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      v[i] = 16'h0005 + 16'($urandom % 32'hfffb);
      host.acc(1'b1, 8'(8 + i), v[i]);
      rd(8'(8 + i), v[i]);
    end
    chk("intervals", {v[3], v[2], v[1], v[0]}, conversion_interval_out);
    chk("offsets", {v[5], v[4]}, {ch1_frequency_offset_out, ch0_frequency_offset_out});
    for (int k = 0; k < 5; k++) begin
      d = 24'($urandom);
      @(posedge clk_in) #1;
      {result_valid_in, result_data_in, amp_report_en_in} = {2'h3, d, k < 4};
      evt[7 - 2 * (k > 3 ? 3 : k) -: 2] = 2'h3;
      @(posedge clk_in) #1;
      {result_valid_in, evt} = 10'h0;
      rd(8'h04, {4'h8 >> k, d[11:0]});
      rd(8'h04, {4'h0, d[11:0]});
      rd(8'h06, {4'h8 >> k, d[23:12]});
      rd(8'h06, {4'h0, d[23:12]});
    end
    host.acc(1'b1, 8'h08, 16'h0005);
    ticks = 0;
    chk("busy idle", 4'h0, conv_busy_out);
    chk("done idle", 4'h0, conv_done_out);
    run_in = 4'hf;
    @(posedge clk_in) #1;
    chk("busy start", 4'hf, conv_busy_out);
    // random tick gaps so the count follows ticks, not cycles
    for (n = 0; n < 2000 && conv_done_out[0] !== 1'b1; n++) begin
      @(posedge clk_in) #1;
      ref_tick_in = 4'($urandom);
    end
    if (n == 2000) fails++;
    chk("ticks", 64'd80, ticks);
    chk("busy", 1'b0, conv_busy_out[0]);
    stop_test;
  end
endmodule // channel_result_config_regs_tb_top

/* File: tb/ind_host_model.sv */
// host model: one-cycle register strobes
`timescale 1ns/1ns
module ind_host_model (
  input  wire        clk_in,
  output reg  [7:0]  addr_out,
  output reg         wr_out,
  output reg         rd_out,
  output reg  [15:0] data_out
);
  initial {addr_out, wr_out, rd_out, data_out} = 26'h0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in) #1;
    {addr_out, data_out, wr_out, rd_out} = {a, d, w, !w};
    @(posedge clk_in) #1;
    // released data flips so stale values never look valid
    {data_out, wr_out, rd_out} = {~d, 2'h0};
  endtask
endmodule // ind_host_model

/* File: tb/ind_regs_chk.sv */
// checker: read timing, interval write and flag set/clear
`timescale 1ns/1ns
module ind_regs_chk (
  input wire logic        clk_in, arst_n_in, reg_wr_en_in, reg_rd_en_in, reg_rd_valid_out, amp_report_en_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [15:0] reg_wr_data_in, reg_rd_data_out,
  input wire logic [1:0]  underrange_evt_in, overrange_evt_in, timeout_evt_in, amp_unsettled_evt_in,
  input wire logic [63:0] conversion_interval_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence rd2;
    reg_rd_en_in && reg_addr_in == 8'h04;
  endsequence
  sequence calm;
    !(underrange_evt_in[0] | overrange_evt_in[0] | timeout_evt_in[0] | amp_unsettled_evt_in[0]);
  endsequence
  property flag(ev, f);
    (ev ##1 rd2) or (ev ##1 !reg_rd_en_in ##1 rd2) |=> f;
  endproperty
  AST_RD_VALID:
    assert property (reg_rd_en_in |=> reg_rd_valid_out) else $error("read valid missing");
  AST_NO_VALID:
    assert property (!reg_rd_en_in |=> !reg_rd_valid_out) else $error("spurious read valid");
  AST_INTERVAL:
    assert property (reg_wr_en_in && reg_addr_in == 8'h08 |=> conversion_interval_out[15:0] == $past(reg_wr_data_in))
    else $error("interval not written");
  AST_UR:
    assert property (flag(underrange_evt_in[0], reg_rd_data_out[15])) else $error("underrange flag lost");
  AST_OR:
    assert property (flag(overrange_evt_in[0], reg_rd_data_out[14])) else $error("overrange flag lost");
  AST_TO:
    assert property (flag(timeout_evt_in[0], reg_rd_data_out[13])) else $error("timeout flag lost");
  AST_AMP:
    assert property (flag(amp_unsettled_evt_in[0] && amp_report_en_in, reg_rd_data_out[12])) else $error("amp flag lost");
  AST_CLR:
    assert property (rd2 ##0 calm ##1 calm ##1 rd2 |=> reg_rd_data_out[15:12] == 4'h0) else $error("flags not cleared");
endmodule // ind_regs_chk
bind channel_result_config_regs ind_regs_chk chk (.*);
